// ---- verilog/etc_pkg.sv ----
// Constants, encodings and carrier types of the enhanced timer channel control block
package etc_pkg;

  localparam int CNT_W = 10;
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN_A_CTRL = 8'h04;
  localparam logic [7:0] OFS_CHAN_B_CTRL = 8'h08;
  localparam logic [7:0] OFS_CNT_LOW = 8'h0c;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h10;
  localparam logic [7:0] OFS_CMP_A_LOW = 8'h14;
  localparam logic [7:0] OFS_CMP_A_HIGH = 8'h18;
  localparam logic [7:0] OFS_CMP_B_LOW = 8'h1c;
  localparam logic [7:0] OFS_CMP_B_HIGH = 8'h20;

  // Timer control register fields
  localparam int PAUSE_BIT = 7;
  localparam int ON_BIT = 3;
  localparam int PERIOD_LSB = 0;
  localparam int PERIOD_W = 3;
  localparam int PERIOD_SHIFT = 7;

  // Channel control register fields
  localparam int MODE_LSB = 6;
  localparam int FUNC_LSB = 4;
  localparam int LEVEL_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int DIR_BIT = 1;
  localparam int CLR_SEL_BIT = 0;
  localparam int ALIGN_LSB = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RESET = 10'h000;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } etc_mode_t;

  // Output function codes, meaning depends on mode
  localparam logic [1:0] FUNC_0 = 2'b00;
  localparam logic [1:0] FUNC_1 = 2'b01;
  localparam logic [1:0] FUNC_2 = 2'b10;
  localparam logic [1:0] FUNC_3 = 2'b11;

  localparam logic [1:0] ALIGN_EDGE = 2'b00;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] func;
    logic level;
    logic invert;
  } etc_chan_cfg_t;

endpackage

// ---- verilog/etc_timer.sv ----
// Enhanced timer: 10-bit counter, two compare/capture channels, AHB-Lite registers
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

//Contract
// - Channel A mode: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer.
// - Timer/counter mode releases the pin; function, level and invert unused.
// - Compare mode match: 00 no change, 01 low, 10 high, 11 toggle.
// - PWM mode function: 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - Capture mode: 00 rising, 01 falling, 10 both edges, 11 disabled.
// - Compare match leaves pin unchanged when requested level equals initial.
// - Enable rising edge returns compare-mode pin to its initial level.
// - Level bit: initial level in compare mode, active level in PWM modes.
// - Invert bit inverts the pin; no effect in timer/counter mode.
// - Read-only direction flag: 0 counting up, 1 counting down.
// - Clear select 1: A match clears; 0: period match or overflow clears.
// - Overflow clearing only when period compare value is zero.
// - Clear select ignored in PWM, single pulse and capture modes.
// - Channel B has identical fields, driving all three of its pins. In the code, channel B bits 1..0 hold the alignment.
// - Alignment: 00 edge, centre with match on up, down, or both.
// - Counter readable only: low byte bits 7..0, high byte bits 9..8.
// - Compare A value read/write as low and high byte, reset zero.
// - Enable rising clears counter; falling stops and keeps count.
// - Period value compares counter top three bits, steps of 128 clocks.
// - Channel B pins change in compare mode only on a B match. The code also returns them to the initial level on an enable rising edge.
module etc_timer (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic count_tick_in,
  input wire logic chan_a_pin_in,
  output logic chan_a_pin_out,
  output logic chan_a_pin_oe_n_out,
  input wire logic [2:0] chan_b_pin_in,
  output logic [2:0] chan_b_pin_out,
  output logic [2:0] chan_b_pin_oe_n_out
);

  localparam int W = etc_pkg::CNT_W;
  logic [7:0] timer_ctrl_reg;
  logic [7:0] chan_a_ctrl_reg;
  logic [7:0] chan_b_ctrl_reg;
  logic [W-1:0] cmp_reg [etc_pkg::NUM_CH];
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic dir_reg;
  logic dir_next;
  logic on_d_reg;
  logic [31:0] rdata_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic on_bit;
  logic pause_bit;
  logic en_rise;
  logic tick;
  logic [2:0] period_val;
  logic [W-1:0] top_val;
  logic centre;
  logic clr_on_a;
  logic [1:0] align;
  etc_pkg::etc_chan_cfg_t cfg [etc_pkg::NUM_CH];
  logic [etc_pkg::NUM_CH-1:0] match_ev;
  logic [etc_pkg::NUM_CH-1:0] cap_ev;
  logic [etc_pkg::NUM_CH-1:0] pin_q;
  logic [etc_pkg::NUM_CH-1:0] oe_n_q;
  logic [3:0] pin_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [etc_pkg::NUM_CH-1:0] cap_pin;
  logic addr_ok;
  logic [7:0] addr_lo;

  assign on_bit = timer_ctrl_reg[etc_pkg::ON_BIT];
  assign pause_bit = timer_ctrl_reg[etc_pkg::PAUSE_BIT];
  assign period_val = timer_ctrl_reg[etc_pkg::PERIOD_LSB +: etc_pkg::PERIOD_W];
  assign align = chan_b_ctrl_reg[etc_pkg::ALIGN_LSB +: 2];
  assign en_rise = on_bit & ~on_d_reg;
  assign tick = on_bit & ~pause_bit & count_tick_in;

  assign cfg[0] = chan_a_ctrl_reg[7:2];
  assign cfg[1] = chan_b_ctrl_reg[7:2];
  // Last count of a period; period value zero wraps to full-scale overflow
  assign top_val = {period_val, 7'h00} - 10'h001;
  assign centre = ((cfg[0].mode == etc_pkg::MODE_PWM) || (cfg[1].mode == etc_pkg::MODE_PWM))
                  && (align != etc_pkg::ALIGN_EDGE);
  // Clear select only steers compare and timer/counter modes
  assign clr_on_a = chan_a_ctrl_reg[etc_pkg::CLR_SEL_BIT]
                    && ((cfg[0].mode == etc_pkg::MODE_CMP) || (cfg[0].mode == etc_pkg::MODE_TMR));

  always_comb
  begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    if (en_rise)
    begin
      cnt_next = '0;
      dir_next = 1'b0;
    end
    else if (tick && !centre)
    begin
      dir_next = 1'b0;
      if (clr_on_a ? (cnt_reg == cmp_reg[0]) : (cnt_reg == top_val))
      begin
        cnt_next = '0;
      end
      else
      begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
    else if (tick)
    begin
      // Centre-aligned: turn down at the top and up at zero
      if (!dir_reg && (cnt_reg == top_val))
      begin
        dir_next = 1'b1;
      end
      else if (dir_reg && (cnt_reg == '0))
      begin
        dir_next = 1'b0;
      end
      cnt_next = dir_next ? (cnt_reg - 10'h001) : (cnt_reg + 10'h001);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt_reg <= '0;
      dir_reg <= 1'b0;
      on_d_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      on_d_reg <= on_bit;
    end
  end

  // Pin inputs pass two flops before capture edge detection
  assign pin_raw = {chan_b_pin_in, chan_a_pin_in};

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  assign cap_pin = {sync2_reg[1], sync2_reg[0]};
  genvar ch;
  generate
    for (ch = 0; ch < etc_pkg::NUM_CH; ch++)
    begin : g_chan
      logic lvl_reg;
      logic cap_prev_reg;
      logic out_reg;
      logic oe_n_reg;
      logic active_lvl;

      assign active_lvl = cfg[ch].level;
      // Matches only count on a counter step; a B match only moves B pins
      assign match_ev[ch] = tick && (cnt_reg == cmp_reg[ch]);

      always_comb
      begin
        cap_ev[ch] = 1'b0;
        if (cfg[ch].mode == etc_pkg::MODE_CAP)
        begin
          case (cfg[ch].func)
            etc_pkg::FUNC_0: cap_ev[ch] = cap_pin[ch] & ~cap_prev_reg;
            etc_pkg::FUNC_1: cap_ev[ch] = ~cap_pin[ch] & cap_prev_reg;
            etc_pkg::FUNC_2: cap_ev[ch] = cap_pin[ch] ^ cap_prev_reg;
            default: cap_ev[ch] = 1'b0;
          endcase
        end
      end

      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          cap_prev_reg <= 1'b0;
        end
        else
        begin
          cap_prev_reg <= cap_pin[ch];
        end
      end

      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          lvl_reg <= 1'b0;
        end
        else
        begin
          case (cfg[ch].mode)
            etc_pkg::MODE_CMP:
            begin
              if (en_rise)
              begin
                lvl_reg <= cfg[ch].level;
              end
              else if (match_ev[ch])
              begin
                case (cfg[ch].func)
                  etc_pkg::FUNC_1: if (cfg[ch].level) lvl_reg <= 1'b0;
                  etc_pkg::FUNC_2: if (!cfg[ch].level) lvl_reg <= 1'b1;
                  etc_pkg::FUNC_3: lvl_reg <= ~lvl_reg;
                  default: lvl_reg <= lvl_reg;
                endcase
              end
            end
            etc_pkg::MODE_PWM:
            begin
              case (cfg[ch].func)
                etc_pkg::FUNC_0: lvl_reg <= ~active_lvl;
                etc_pkg::FUNC_1: lvl_reg <= active_lvl;
                etc_pkg::FUNC_2:
                begin
                  if (en_rise)
                  begin
                    lvl_reg <= active_lvl;
                  end
                  else if (match_ev[ch] && (!centre || (!dir_reg && align[0])))
                  begin
                    lvl_reg <= ~active_lvl;
                  end
                  else if ((match_ev[ch] && dir_reg && align[1]) || (tick && (cnt_reg == '0)))
                  begin
                    lvl_reg <= active_lvl;
                  end
                end
                default:
                begin
                  // Single pulse: starts on enable, ends on the first match
                  if (en_rise)
                  begin
                    lvl_reg <= active_lvl;
                  end
                  else if (match_ev[ch])
                  begin
                    lvl_reg <= ~active_lvl;
                  end
                end
              endcase
            end
            default: lvl_reg <= lvl_reg;
          endcase
        end
      end

      // Capture and timer/counter modes release the pin
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          out_reg <= 1'b0;
          oe_n_reg <= 1'b1;
        end
        else
        begin
          out_reg <= lvl_reg ^ cfg[ch].invert;
          oe_n_reg <= (cfg[ch].mode == etc_pkg::MODE_CAP)
                      || (cfg[ch].mode == etc_pkg::MODE_TMR);
        end
      end

      assign pin_q[ch] = out_reg;
      assign oe_n_q[ch] = oe_n_reg;
    end
  endgenerate

  assign chan_a_pin_out = pin_q[0];
  assign chan_a_pin_oe_n_out = oe_n_q[0];
  assign chan_b_pin_out = {3{pin_q[1]}};
  assign chan_b_pin_oe_n_out = {3{oe_n_q[1]}};

  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_reg;
  assign addr_lo = haddr_in[etc_pkg::ADDR_W-1:0];
  assign addr_ok = hsel_in && htrans_in[1] && hready_in;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= addr_ok && hwrite_in;
      wr_addr_reg <= addr_lo;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_reg <= '0;
    end
    else if (addr_ok && !hwrite_in)
    begin
      case (addr_lo)
        etc_pkg::OFS_TIMER_CTRL: rdata_reg <= {24'h000000, timer_ctrl_reg};
        etc_pkg::OFS_CHAN_A_CTRL: rdata_reg <= {24'h000000, chan_a_ctrl_reg[7:2], dir_reg,
                                                chan_a_ctrl_reg[0]};
        etc_pkg::OFS_CHAN_B_CTRL: rdata_reg <= {24'h000000, chan_b_ctrl_reg};
        etc_pkg::OFS_CNT_LOW: rdata_reg <= {24'h000000, cnt_reg[7:0]};
        etc_pkg::OFS_CNT_HIGH: rdata_reg <= {30'h00000000, cnt_reg[9:8]};
        etc_pkg::OFS_CMP_A_LOW: rdata_reg <= {24'h000000, cmp_reg[0][7:0]};
        etc_pkg::OFS_CMP_A_HIGH: rdata_reg <= {30'h00000000, cmp_reg[0][9:8]};
        etc_pkg::OFS_CMP_B_LOW: rdata_reg <= {24'h000000, cmp_reg[1][7:0]};
        etc_pkg::OFS_CMP_B_HIGH: rdata_reg <= {30'h00000000, cmp_reg[1][9:8]};
        default: rdata_reg <= '0;
      endcase
    end
  end

  // Counter registers have no write path; direction bit writes are dropped
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      timer_ctrl_reg <= etc_pkg::CTRL_RESET;
      chan_a_ctrl_reg <= etc_pkg::CTRL_RESET;
      chan_b_ctrl_reg <= etc_pkg::CTRL_RESET;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        etc_pkg::OFS_TIMER_CTRL: timer_ctrl_reg <= hwdata_in[7:0];
        etc_pkg::OFS_CHAN_A_CTRL: chan_a_ctrl_reg <= {hwdata_in[7:2], 1'b0,
                                                      hwdata_in[0]};
        etc_pkg::OFS_CHAN_B_CTRL: chan_b_ctrl_reg <= hwdata_in[7:0];
        default: timer_ctrl_reg <= timer_ctrl_reg;
      endcase
    end
  end

  // Capture loads the counter value into the channel compare register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cmp_reg[0] <= etc_pkg::CMP_RESET;
      cmp_reg[1] <= etc_pkg::CMP_RESET;
    end
    else
    begin
      for (int i = 0; i < etc_pkg::NUM_CH; i++)
      begin
        if (cap_ev[i])
        begin
          cmp_reg[i] <= cnt_reg;
        end
        else if (wr_pend_reg && (wr_addr_reg == ((i == 0) ? etc_pkg::OFS_CMP_A_LOW
                                                          : etc_pkg::OFS_CMP_B_LOW)))
        begin
          cmp_reg[i][7:0] <= hwdata_in[7:0];
        end
        else if (wr_pend_reg && (wr_addr_reg == ((i == 0) ? etc_pkg::OFS_CMP_A_HIGH
                                                          : etc_pkg::OFS_CMP_B_HIGH)))
        begin
          cmp_reg[i][9:8] <= hwdata_in[1:0];
        end
      end
    end
  end

endmodule // etc_timer

// ---- dv/etc_timer_chk.sv ----
// Port checker for the enhanced timer channel control block
`timescale 1ns/1ps
module etc_timer_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic chan_a_pin_oe_n_out,
  input wire logic [2:0] chan_b_pin_out,
  input wire logic [2:0] chan_b_pin_oe_n_out
);
  logic wr_reg;
  logic [7:0] wa_reg;
  logic [1:0] ma_reg;
  logic [1:0] mb_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // Tracks the channel modes software has written
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      wr_reg <= 1'b0;
      wa_reg <= 8'h00;
      ma_reg <= 2'b00;
      mb_reg <= 2'b00;
    end
    else
    begin
      wr_reg <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
      wa_reg <= haddr_in[7:0];
      if (wr_reg && wa_reg == etc_pkg::OFS_CHAN_A_CTRL)
        ma_reg <= hwdata_in[7:6];
      if (wr_reg && wa_reg == etc_pkg::OFS_CHAN_B_CTRL)
        mb_reg <= hwdata_in[7:6];
    end

  sequence s_rd(logic [7:0] a);
    hsel_in && htrans_in[1] && hready_in && !hwrite_in && haddr_in[7:0] == a;
  endsequence

  property p_ready;
    hreadyout_out && !hresp_out;
  endproperty
  a_ready: assert property (p_ready) else $error("Bus slave not ready or not okay");
  property p_cnt_lo;
    s_rd(etc_pkg::OFS_CNT_LOW) |=> hrdata_out[31:8] == 24'h000000;
  endproperty
  a_cnt_lo: assert property (p_cnt_lo) else $error("Counter low read too wide");
  property p_cnt_hi;
    s_rd(etc_pkg::OFS_CNT_HIGH) |=> hrdata_out[31:2] == 30'h00000000;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("Counter high unused bits set");
  property p_cmp_hi;
    s_rd(etc_pkg::OFS_CMP_A_HIGH) |=> hrdata_out[31:2] == 30'h00000000;
  endproperty
  a_cmp_hi: assert property (p_cmp_hi) else $error("Compare high unused bits set");
  property p_unmap;
    s_rd(8'h40) |=> hrdata_out == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("Unmapped read not zero");
  property p_bpin;
    chan_b_pin_out == {3{chan_b_pin_out[0]}} && chan_b_pin_oe_n_out == {3{chan_b_pin_oe_n_out[0]}};
  endproperty
  a_bpin: assert property (p_bpin) else $error("Channel B pins differ");
  // Capture and timer modes both have mode bit 0 set: pin released
  property p_aoe;
    ma_reg[0] [*3] |-> chan_a_pin_oe_n_out;
  endproperty
  a_aoe: assert property (p_aoe) else $error("Channel A pin driven while released");
  property p_boe;
    mb_reg[0] [*3] |-> chan_b_pin_oe_n_out == 3'b111;
  endproperty
  a_boe: assert property (p_boe) else $error("Channel B pins driven while released");
endmodule // etc_timer_chk

bind etc_timer etc_timer_chk i_chk (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .chan_a_pin_oe_n_out(chan_a_pin_oe_n_out),
  .chan_b_pin_out(chan_b_pin_out), .chan_b_pin_oe_n_out(chan_b_pin_oe_n_out));

// ---- dv/etc_pin_model.sv ----
// Model of the external circuit on the timer channel pins
`timescale 1ns/1ps
module etc_pin_model (
  input wire logic a_out_in,
  input wire logic a_oe_n_in,
  input wire logic [2:0] b_out_in,
  input wire logic [2:0] b_oe_n_in,
  input wire logic a_ext_in,
  input wire logic b_ext_in,
  output logic a_wire_out,
  output logic [2:0] b_wire_out
);
  // Released pins follow the external source, driven pins follow the block
  assign a_wire_out = a_oe_n_in ? a_ext_in : a_out_in;
  always_comb
    for (int i = 0; i < 3; i++)
      b_wire_out[i] = b_oe_n_in[i] ? b_ext_in : b_out_in[i];
endmodule // etc_pin_model

// ---- dv/etc_timer_tb.sv ----
// Self-checking testbench of the enhanced timer channel control block
`timescale 1ns/1ps
module etc_timer_tb;
  localparam logic [7:0] T = etc_pkg::OFS_TIMER_CTRL;
  localparam logic [7:0] CA = etc_pkg::OFS_CHAN_A_CTRL;
  localparam logic [7:0] CB = etc_pkg::OFS_CHAN_B_CTRL;
  localparam logic [7:0] NL = etc_pkg::OFS_CNT_LOW;
  localparam logic [7:0] AL = etc_pkg::OFS_CMP_A_LOW;
  localparam logic [7:0] BL = etc_pkg::OFS_CMP_B_LOW;
  logic clk_in, nrst_in, hsel, hwrite, hready, hresp, tick, a_ext, b_ext, a_out, a_oe_n, a_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] b_out, b_oe_n, b_pin;
  logic e;
  int mismatches;
  int samples_checked;

  etc_timer i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .count_tick_in(tick), .chan_a_pin_in(a_pin), .chan_a_pin_out(a_out),
    .chan_a_pin_oe_n_out(a_oe_n), .chan_b_pin_in(b_pin), .chan_b_pin_out(b_out),
    .chan_b_pin_oe_n_out(b_oe_n));
  etc_pin_model i_pins (.a_out_in(a_out), .a_oe_n_in(a_oe_n), .b_out_in(b_out),
    .b_oe_n_in(b_oe_n), .a_ext_in(a_ext), .b_ext_in(b_ext), .a_wire_out(a_pin),
    .b_wire_out(b_pin));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task test_done;
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'h000000, d}, r);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    xfer(1'b0, a, 32'h00000000, r);
    chk(r, x);
  endtask

  task ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      tick <= 1'b1;
      @(posedge clk_in);
      tick <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
  endtask

  task pins(input logic [3:0] x);
    chk({28'h0000000, b_pin, a_pin}, {28'h0000000, x});
  endtask

  task t_regs;
    for (int i = 0; i < 10; i++)
      rdc(8'(i * 4), 32'h00000000);
    rdc(8'h40, 32'h00000000);
    wr(AL, 8'ha5);
    wr(etc_pkg::OFS_CMP_A_HIGH, 8'hff);
    rdc(AL, 32'h000000a5);
    rdc(etc_pkg::OFS_CMP_A_HIGH, 32'h00000003);
    wr(etc_pkg::OFS_CMP_A_HIGH, 8'h00);
    wr(NL, 8'h55);
    rdc(NL, 32'h00000000);
    wr(CA, 8'h02);
    rdc(CA, 32'h00000000);
  endtask

  task t_count;
    wr(T, 8'h08);
    ticks(5);
    rdc(NL, 32'h00000005);
    wr(T, 8'h00);
    ticks(3);
    rdc(NL, 32'h00000005);
    wr(T, 8'h09);
    ticks(130);
    rdc(NL, 32'h00000002);
    wr(T, 8'h00);
    wr(T, 8'h08);
    ticks(1026);
    rdc(NL, 32'h00000002);
    wr(T, 8'h00);
    wr(AL, 8'h03);
    wr(CA, 8'h01);
    wr(T, 8'h08);
    ticks(5);
    rdc(NL, 32'h00000001);
    wr(T, 8'h00);
    wr(CA, 8'h81);
    wr(T, 8'h08);
    ticks(5);
    rdc(NL, 32'h00000005);
  endtask

  task t_cmp;
    logic [7:0] c;
    for (int f = 0; f < 4; f++)
      for (int j = 0; j < 4; j++)
      begin
        c = {2'b00, 2'(f), 2'(j), 2'b00};
        wr(T, 8'h00);
        wr(BL, 8'h06);
        wr(CA, c);
        wr(CB, c);
        wr(T, 8'h08);
        ticks(0);
        pins({4{c[3] ^ c[2]}});
        e = (f == 0) ? c[3] : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : ~c[3];
        ticks(4);
        pins({{3{c[3] ^ c[2]}}, e ^ c[2]});
        ticks(3);
        pins({4{e ^ c[2]}});
      end
  endtask

  task t_cap;
    wr(T, 8'h00);
    wr(CA, 8'hc0);
    wr(CB, 8'hc0);
    a_ext <= 1'b1;
    b_ext <= 1'b1;
    ticks(0);
    pins(4'hf);
    a_ext <= 1'b0;
    wr(CA, 8'h40);
    wr(CB, 8'h50);
    wr(T, 8'h08);
    ticks(7);
    a_ext <= 1'b1;
    b_ext <= 1'b0;
    ticks(0);
    ticks(2);
    a_ext <= 1'b0;
    b_ext <= 1'b1;
    ticks(0);
    rdc(AL, 32'h00000007);
    rdc(BL, 32'h00000007);
    wr(CA, 8'h60);
    a_ext <= 1'b1;
    ticks(0);
    ticks(1);
    wr(CA, 8'h70);
    a_ext <= 1'b0;
    ticks(0);
    rdc(AL, 32'h00000009);
  endtask

  task t_pwm;
    wr(T, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      wr(CA, {3'b100, 3'(k), 2'b00});
      wr(CB, {3'b100, 3'(k), 2'b00});
      ticks(0);
      pins({4{~^k[2:0]}});
    end
    wr(AL, 8'h03);
    wr(CA, 8'hb8);
    wr(CB, 8'h01);
    wr(T, 8'h08);
    ticks(0);
    chk({31'h00000000, a_pin}, 32'h00000001);
    ticks(4);
    chk({31'h00000000, a_pin}, 32'h00000000);
    ticks(1030);
    rdc(CA, 32'h000000ba);
    wr(T, 8'h00);
    wr(CB, 8'h00);
    wr(CA, 8'ha8);
    wr(T, 8'h09);
    ticks(0);
    chk({31'h00000000, a_pin}, 32'h00000001);
    ticks(4);
    chk({31'h00000000, a_pin}, 32'h00000000);
    ticks(125);
    chk({31'h00000000, a_pin}, 32'h00000001);
  endtask

  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    {nrst_in, hsel, hwrite, tick, a_ext, b_ext} = 6'h00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_count();
    t_cmp();
    t_cap();
    t_pwm();
    test_done();
  end

  initial
  begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule // etc_timer_tb
